// ### rtl/multiplier_pipe_regs.svh
// Timing counts and widths of the multiplier contention interlock.
`ifndef MULTIPLIER_PIPE_REGS_SVH
`define MULTIPLIER_PIPE_REGS_SVH

// Width of the multiplier busy counter.
`define BUSY_COUNT_W       3
// Busy cycles left after a signed word multiply hands over its operands.
`define SWM_BUSY_CYCLES    3'h2
// Busy cycles after the second access of a word multiply-accumulate.
`define MACW_BUSY_CYCLES   3'h2
// Busy cycles after the second access of a long multiply-accumulate.
`define MACL_BUSY_CYCLES   3'h4
// Pipeline steps of a signed word multiply, busy cycles included.
`define SWM_PIPE_STEPS     3'h6

`endif

// ### rtl/multiplier_pipe_pkg.sv
// Types shared by the multiplier contention interlock.
`include "multiplier_pipe_regs.svh"

package multiplier_pipe_pkg;

  typedef enum logic [1:0] {
    kind_other = 2'h0,
    kind_swm   = 2'h1,
    kind_macw  = 2'h2,
    kind_macl  = 2'h3
  } access_kind_t;

  typedef struct packed {
    logic         start;
    access_kind_t kind;
    logic         second;
  } access_req_t;

  typedef enum logic [2:0] {
    st_idle    = 3'h1,
    st_stretch = 3'h2,
    st_split   = 3'h4
  } slot_state_t;

  typedef struct packed {
    logic [`BUSY_COUNT_W-1:0] count;
    logic                     busy;
  } busy_state_t;

  typedef struct packed {
    slot_state_t              state;
    logic                     ma_pend;
    access_kind_t             ma_kind;
    logic                     ma_second;
    logic                     fetch_pend;
    logic                     stall;
    logic                     ma_done;
    access_kind_t             done_kind;
    logic                     fetch_done;
    logic                     mult_load;
    logic [`BUSY_COUNT_W-1:0] load_value;
  } interlock_state_t;

endpackage

// ### rtl/mult_busy_counter.sv
// Counts the cycles in which the shared multiplier is still operating.
`timescale 1ns/1ns

module mult_busy_counter
  import multiplier_pipe_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset,
  // Load from the interlock
  input  wire logic                     load,
  input  wire logic [`BUSY_COUNT_W-1:0] load_value,
  // Status
  output logic      [`BUSY_COUNT_W-1:0] count,
  output logic                          busy
);

  busy_state_t q;
  busy_state_t next_q;

  // The count runs down every cycle, regardless of slot boundaries.
  always_comb begin
    next_q = q;
    if (load) begin
      next_q.count = load_value;
    end else if (q.count != {`BUSY_COUNT_W{1'b0}}) begin
      next_q.count = q.count - {{(`BUSY_COUNT_W-1){1'b0}}, 1'b1};
    end
    // Busy is registered so that the status pin comes straight from a flip-flop.
    next_q.busy = (next_q.count != {`BUSY_COUNT_W{1'b0}});
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign count = q.count;
  assign busy  = q.busy;

endmodule

// ### rtl/multiplier_interlock.sv
// Multiplier contention and fetch split interlock of the CPU pipeline.
// Summary of operation
// - Accumulate second access never waits on busy.
// - Signed multiply access hands operands to multiplier.
// - Signed multiply access stretches until the multiplier's last busy cycle.
// - Intervening instruction means no multiply stall.
// - Access colliding with fetch splits the slot.
// - Stretched access still splits with colliding fetch.
// - Multiplier stays busy two cycles after signed multiply or word accumulate second access, four after long accumulate second access.
// - Unrelated follower sees plain four-stage multiply.
// - Signed multiply takes six pipeline steps.
`timescale 1ns/1ns

module multiplier_interlock
  import multiplier_pipe_pkg::*;
#(
  parameter logic [`BUSY_COUNT_W-1:0] swm_busy  = `SWM_BUSY_CYCLES,
  parameter logic [`BUSY_COUNT_W-1:0] macw_busy = `MACW_BUSY_CYCLES,
  parameter logic [`BUSY_COUNT_W-1:0] macl_busy = `MACL_BUSY_CYCLES
)
(
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // Requests from the pipeline
  input  wire multiplier_pipe_pkg::access_req_t access,
  input  wire logic                       fetch_start,
  // Slot control back to the pipeline
  output logic                            stall,
  output logic                            ma_done,
  output logic                            fetch_done,
  // Multiplier status
  output logic                            mult_load,
  output logic                            mult_busy
);

  import multiplier_pipe_pkg::*;

  interlock_state_t         q;
  interlock_state_t         next_q;
  logic [`BUSY_COUNT_W-1:0] count;
  logic [`BUSY_COUNT_W-1:0] count_ahead;
  logic                     take;
  logic                     pend_ma;
  logic                     pend_fetch;
  access_kind_t             kind;
  logic                     second;
  logic                     wait_mult;

  // ************************************************************
  // Multiplier busy counter
  // ************************************************************

  mult_busy_counter busy_counter (
    .clock      (clock),
    .reset      (reset),
    .load       (q.mult_load),
    .load_value (q.load_value),
    .count      (count),
    .busy       (mult_busy)
  );

  // ************************************************************
  // Slot decision
  // ************************************************************

  // New requests are taken only while the pipeline is not held.
  assign take       = ~q.stall;
  assign pend_ma    = q.ma_pend | (access.start & take);
  assign pend_fetch = q.fetch_pend | (fetch_start & take);
  assign kind       = q.ma_pend ? q.ma_kind : access.kind;
  assign second     = q.ma_pend ? q.ma_second : access.second;

  // The count the multiplier will show in the cycle the access is performed.
  assign count_ahead = q.mult_load ? q.load_value
                     : (count != {`BUSY_COUNT_W{1'b0}})
                       ? count - {{(`BUSY_COUNT_W-1){1'b0}}, 1'b1} : count;

  // Only a signed word multiply waits; it may merge with the last busy cycle.
  assign wait_mult = pend_ma & (kind == kind_swm)
                   & (count_ahead > {{(`BUSY_COUNT_W-1){1'b0}}, 1'b1});

  always_comb begin
    next_q            = q;
    next_q.ma_done    = 1'b0;
    next_q.fetch_done = 1'b0;
    next_q.mult_load  = 1'b0;
    next_q.load_value = q.load_value;
    next_q.ma_pend    = pend_ma;
    next_q.ma_kind    = kind;
    next_q.ma_second  = second;
    next_q.fetch_pend = pend_fetch;
    case (q.state)
      st_idle, st_stretch: begin
        if (wait_mult) begin
          next_q.state = st_stretch;
        end else if (pend_ma) begin
          // Other kinds never wait on the multiplier.
          next_q.ma_done   = 1'b1;
          next_q.done_kind = kind;
          next_q.ma_pend   = 1'b0;
          if (kind == kind_swm) begin
            next_q.mult_load  = 1'b1;
            next_q.load_value = swm_busy;
          end else if ((kind == kind_macw) && second) begin
            next_q.mult_load  = 1'b1;
            next_q.load_value = macw_busy;
          end else if ((kind == kind_macl) && second) begin
            next_q.mult_load  = 1'b1;
            next_q.load_value = macl_busy;
          end
          // A colliding fetch is serviced in the following cycle.
          next_q.state = pend_fetch ? st_split : st_idle;
        end else if (pend_fetch) begin
          next_q.fetch_done = 1'b1;
          next_q.fetch_pend = 1'b0;
          next_q.state      = st_idle;
        end else begin
          next_q.state = st_idle;
        end
      end
      st_split: begin
        next_q.fetch_done = 1'b1;
        next_q.fetch_pend = 1'b0;
        next_q.state      = st_idle;
      end
      default: begin
        next_q.state = st_idle;
      end
    endcase
    next_q.stall = next_q.ma_pend | next_q.fetch_pend;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q       <= '0;
      q.state <= st_idle;
    end else begin
      q <= next_q;
    end
  end

  assign stall      = q.stall;
  assign ma_done    = q.ma_done;
  assign fetch_done = q.fetch_done;
  assign mult_load  = q.mult_load;

  // ************************************************************
  // Checks
  // ************************************************************

  // All checks run on the pipeline clock and rest while reset is high.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence swm_handover_s;
    q.mult_load && (q.load_value == swm_busy) ##1 !q.mult_load;
  endsequence

  sequence busy_tail_s;
    (count == swm_busy) ##1 (count == swm_busy - 3'h1);
  endsequence

  busy_two_a: assert property (swm_handover_s |-> busy_tail_s)
    else $error("multiplier busy tail is not two cycles");

  swm_load_a: assert property (q.ma_done && (q.done_kind == kind_swm)
    |-> q.mult_load && (q.load_value == swm_busy))
    else $error("signed multiply access did not hand operands over");

  swm_no_clash_a: assert property (q.ma_done && (q.done_kind == kind_swm)
    |-> count <= 3'h1)
    else $error("signed multiply access overlaps busy multiplier");

  mac_no_wait_a: assert property (access.start && !q.stall && !fetch_start
    && (access.kind == kind_macw || access.kind == kind_macl)
    |=> q.ma_done)
    else $error("accumulate access was held");

  other_no_wait_a: assert property (access.start && !q.stall
    && (access.kind == kind_other) |=> q.ma_done)
    else $error("unrelated access was held");

  split_a: assert property (access.start && fetch_start && !q.stall
    && (access.kind == kind_other)
    |=> q.ma_done && !q.fetch_done ##1 q.fetch_done && !q.ma_done)
    else $error("colliding fetch did not split the slot");

  fetch_alone_a: assert property (fetch_start && !access.start && !q.stall
    |=> q.fetch_done && !q.ma_done && !q.stall)
    else $error("lone fetch was not serviced at once");

  stretch_split_a: assert property ((q.state == st_stretch) && q.fetch_pend
    ##1 (q.state != st_stretch) |-> q.ma_done ##1 q.fetch_done)
    else $error("stretched access did not split with fetch");

  stretch_bound_a: assert property ((q.state == st_stretch)
    |-> ##[1:4] (q.state != st_stretch))
    else $error("stretch outlasted the multiplier");

  stretch_hold_a: assert property ((q.state == st_stretch)
    |-> q.stall && !q.ma_done)
    else $error("stretched access was not held");

  // A multiply taken in the handover cycle of another merges with its last busy cycle.
  sequence swm_take_s;
    access.start && !q.stall && (access.kind == kind_swm);
  endsequence

  sequence wait_one_s;
    !q.ma_done ##1 q.ma_done;
  endsequence

  back_to_back_a: assert property (q.mult_load && (q.load_value == swm_busy)
    ##0 swm_take_s |=> wait_one_s)
    else $error("back to back multiply did not merge with last busy cycle");

  gap_no_stall_a: assert property (q.ma_done && (q.done_kind == kind_swm)
    && access.start && !q.stall && !fetch_start && (access.kind == kind_other)
    ##1 (access.start && !q.stall && !fetch_start && access.kind == kind_swm)
    |=> q.ma_done)
    else $error("multiply stalled despite an instruction between");

endmodule

// ### tb/tb.sv
// Self-checking testbench of the multiplier contention interlock.
`timescale 1ns/1ns

module tb;
  import multiplier_pipe_pkg::*;

  // ****************************************
  // Clock, reset and stimulus
  // ****************************************
  logic        clock;
  logic        reset;
  access_req_t access;
  logic        fetch_start;
  logic        stall;
  logic        ma_done;
  logic        fetch_done;
  logic        mult_load;
  logic        mult_busy;
  int          failures;
  int          compares;
  int          cycles;

  typedef struct packed {
    logic [4:0]  r0;
    logic [4:0]  r1;
    logic [4:0]  r2;
    logic [29:0] exp;
  } row_t;

  row_t rows [9];

  multiplier_interlock u_dut (
    .clock       (clock),
    .reset       (reset),
    .access      (access),
    .fetch_start (fetch_start),
    .stall       (stall),
    .ma_done     (ma_done),
    .fetch_done  (fetch_done),
    .mult_load   (mult_load),
    .mult_busy   (mult_busy)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic drive(input logic [4:0] r);
    access      = access_req_t'(r[4:1]);
    fetch_start = r[0];
  endtask

  task automatic check(input string name, input logic [29:0] got, input logic [29:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, name, got, exp);
    end
  endtask

  // Applies up to three requests on consecutive cycles and records six cycles of outputs.
  task automatic run(input string name, input logic [4:0] r0, input logic [4:0] r1,
                     input logic [4:0] r2, input logic [29:0] exp);
    logic [5:0] ma;
    logic [5:0] fd;
    logic [5:0] ml;
    logic [5:0] mb;
    logic [5:0] st;
    for (int i = 0; i < 7; i++) begin
      @(negedge clock);
      if (i > 0) begin
        ma[6-i] = ma_done;
        fd[6-i] = fetch_done;
        ml[6-i] = mult_load;
        mb[6-i] = mult_busy;
        st[6-i] = stall;
      end
      drive(i == 0 ? r0 : i == 1 ? r1 : i == 2 ? r2 : 5'h00);
    end
    repeat (6) @(negedge clock);
    check(name, {ma, fd, ml, mb, st}, exp);
    $display("test %s done", name);
  endtask

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset    = 1'b1;
    failures = 0;
    compares = 0;
    cycles   = 0;
    drive(5'h00);
    rows[0] = {5'h01, 5'h00, 5'h00, 6'h00, 6'h20, 6'h00, 6'h00, 6'h00};
    rows[1] = {5'h10, 5'h00, 5'h00, 6'h20, 6'h00, 6'h00, 6'h00, 6'h00};
    rows[2] = {5'h11, 5'h00, 5'h00, 6'h20, 6'h10, 6'h00, 6'h00, 6'h20};
    rows[3] = {5'h14, 5'h00, 5'h00, 6'h20, 6'h00, 6'h20, 6'h18, 6'h00};
    rows[4] = {5'h15, 5'h00, 5'h00, 6'h20, 6'h10, 6'h20, 6'h18, 6'h20};
    rows[5] = {5'h1A, 5'h00, 5'h00, 6'h20, 6'h00, 6'h20, 6'h18, 6'h00};
    rows[6] = {5'h1E, 5'h00, 5'h00, 6'h20, 6'h00, 6'h20, 6'h1E, 6'h00};
    rows[7] = {5'h18, 5'h00, 5'h00, 6'h20, 6'h00, 6'h00, 6'h00, 6'h00};
    rows[8] = {5'h1C, 5'h00, 5'h00, 6'h20, 6'h00, 6'h00, 6'h00, 6'h00};
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    foreach (rows[i]) begin
      run($sformatf("row%0d", i), rows[i].r0, rows[i].r1, rows[i].r2, rows[i].exp);
    end
    // The third request of the first case arrives while stalled and must be ignored.
    run("swm_swm", 5'h14, 5'h14, 5'h10, {6'h28, 6'h00, 6'h28, 6'h1E, 6'h10});
    run("swm_gap_swm", 5'h14, 5'h10, 5'h14, {6'h38, 6'h00, 6'h28, 6'h1E, 6'h00});
    run("swm_swm_fetch", 5'h14, 5'h15, 5'h00, {6'h28, 6'h04, 6'h28, 6'h1E, 6'h18});
    run("swm_macw", 5'h14, 5'h1A, 5'h00, {6'h30, 6'h00, 6'h30, 6'h1C, 6'h00});
    run("swm_macl", 5'h14, 5'h1E, 5'h00, {6'h30, 6'h00, 6'h30, 6'h1F, 6'h00});
    // A reset in mid-operation clears every output at the next edge.
    @(negedge clock);
    drive(5'h14);
    @(negedge clock);
    drive(5'h15);
    reset = 1'b1;
    @(negedge clock);
    check("reset", {25'h0, stall, ma_done, fetch_done, mult_load, mult_busy}, 30'h0);
    drive(5'h00);
    reset = 1'b0;
    $display("test reset done");
    run("after_reset", 5'h14, 5'h00, 5'h00, {6'h20, 6'h00, 6'h20, 6'h18, 6'h00});
    summarize();
  end

endmodule
